// [rtl/flut_defs.vh]
// Register indices, field positions and reset values of the fan table slice
`ifndef FLUT_DEFS_VH
`define FLUT_DEFS_VH

// ************************************************
// Register indices (byte address is four times)
// ************************************************
`define FLUT_IDX_UNLOCK 8'h4A
`define FLUT_IDX_CFG 8'h4C
`define FLUT_IDX_TOFS 8'h4E
`define FLUT_IDX_THR2 8'h52
`define FLUT_IDX_DUTY2 8'h53
`define FLUT_IDX_THR3 8'h54
`define FLUT_IDX_DUTY3 8'h55
`define FLUT_IDX_THR4 8'h56

// ************************************************
// Field positions
// ************************************************
`define FLUT_UNLOCK_BIT 5
`define FLUT_CFG_THI_BIT 0
`define FLUT_CFG_DHI_BIT 1
`define FLUT_CFG_F22K_BIT 2
`define FLUT_THR_TOP_BIT 7
`define FLUT_DUTY_EXT_MSB 7
`define FLUT_DUTY_EXT_LSB 6
`define FLUT_DUTY_LOW_MSB 5
`define FLUT_ADDR_IDX_MSB 9
`define FLUT_ADDR_IDX_LSB 2

// ************************************************
// Reset values
// ************************************************
`define FLUT_RST_THR 8'h7F
`define FLUT_RST_DUTY 8'h3F
`define FLUT_RST_UNLOCK 8'h00
`define FLUT_RST_CFG 3'h0
`define FLUT_RST_TOFS 8'h00
`define FLUT_RST_WORD 32'h0000_0000

`endif

// [rtl/flut_apb_slave.v]
// APB slave front end with registered, zero-wait answer
`timescale 1ns/100ps
`include "flut_defs.vh"

module flut_apb_slave
(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Register file side
  output wire [7:0] reg_idx_o,
  output wire wr_en_o,
  output wire [7:0] wr_data_o,
  input wire [7:0] rd_data_i,
  input wire mapped_i
);

  reg [31:0] prdata_reg;
  reg pready_reg;
  reg pslverr_reg;
  wire setup;
  wire aligned;
  wire hit;

  // ************************************************
  // Decode
  // ************************************************
  assign setup = psel_i & ~penable_i;
  assign aligned = (paddr_i[11:10] == 2'h0) & (paddr_i[1:0] == 2'h0);
  assign hit = aligned & mapped_i;
  assign reg_idx_o = paddr_i[`FLUT_ADDR_IDX_MSB:`FLUT_ADDR_IDX_LSB];
  assign wr_data_o = pwdata_i[7:0];
  assign wr_en_o = psel_i & penable_i & pready_reg & pwrite_i & ~pslverr_reg;

  // ************************************************
  // Answer registers
  // ************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      prdata_reg <= `FLUT_RST_WORD;
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
    end
    else if (ce_i)
    begin
      if (setup)
      begin
        prdata_reg <= hit ? {24'h00_0000, rd_data_i} : `FLUT_RST_WORD;
        pready_reg <= 1'b1;
        pslverr_reg <= ~hit;
      end
      else
      begin
        pready_reg <= 1'b0;
        pslverr_reg <= 1'b0;
      end
    end
  end

  assign prdata_o = prdata_reg;
  assign pready_o = pready_reg;
  assign pslverr_o = pslverr_reg;

endmodule // flut_apb_slave

// [rtl/flut_thr_cmp.v]
// Threshold comparator for one table entry
`timescale 1ns/100ps
`include "flut_defs.vh"

module flut_thr_cmp
(
  // Entry and measurement
  input wire [7:0] thr_i,
  input wire [7:0] ofs_i,
  input wire [8:0] temp_i,
  input wire thi_i,
  // Result
  output wire above_o
);

  wire [9:0] thr_half;
  wire [9:0] ofs_half;
  wire [9:0] eff_thr;
  wire [9:0] temp_used;

  // ************************************************
  // Effective threshold in half degrees
  // ************************************************
  // Sign assumed zero: threshold is an unsigned magnitude
  assign thr_half = thi_i ? {2'b00, thr_i[6:0], thr_i[`FLUT_THR_TOP_BIT]} // RULE4 RULE8
                          : {2'b00, thr_i[6:0], 1'b0}; // RULE3 RULE5
  assign ofs_half = {1'b0, ofs_i, 1'b0};
  assign eff_thr = thr_half + ofs_half; // RULE9

  // ************************************************
  // Compare
  // ************************************************
  assign temp_used = thi_i ? {1'b0, temp_i} : {1'b0, temp_i[8:1], 1'b0}; // RULE6
  assign above_o = temp_used > eff_thr; // RULE5

endmodule // flut_thr_cmp

// [rtl/flut_regs_top.v]
// Fan table entry registers with threshold selection and APB access
//
// The APB register port was chosen for this implementation.
`timescale 1ns/100ps
`include "flut_defs.vh"

// Behaviour
// RULE1: Entry two duty low six bits hold the low resolution duty used above entry two's limit.
// RULE2: Entry three threshold resets with top bit zero and low seven bits all ones.
// RULE3: In low resolution temperature mode entry three's threshold top bit reads zero.
// RULE4: In high resolution temperature mode the top bit joins the low seven to form the limit.
// RULE5: The limit spans 0 to 127.5 in half steps high, 0 to 127 in whole steps low.
// RULE6: Nine temperature bits are compared in high resolution, eight in low resolution.
// RULE7: Above entry three's limit the fan duty is entry three's duty register.
// RULE8: Thresholds are unsigned, the sign bit taken as zero.
// RULE9: The table temperature offset register is added to each programmed limit.
// RULE10: Entry three duty low six bits reset to ones and hold its low resolution duty.
// RULE11: In low resolution duty mode entry three's two upper duty bits read zero.
// RULE12: In high resolution duty mode the upper two bits join the low six for eight bits.
// RULE13: The upper duty bits only act when the 22.5 kHz PWM rate is chosen.
// RULE14: Entry four threshold top bit resets to zero.
// RULE15: Entry registers always read, and take writes only while unlock bit 5 is one.
// RULE16: With several limits passed the highest passed entry's duty applies.
module flut_regs_top
(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [11:0] paddr_i,
  input wire [31:0] pwdata_i,
  output wire [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  // Measurement, half degree units
  input wire [8:0] remote_temp_i,
  // Fan duty result
  output reg [7:0] duty_o,
  output reg duty_valid_o,
  output reg [2:0] entry_above_o
);

  // ************************************************
  // Declarations
  // ************************************************
  reg [7:0] unlock_reg;
  reg [2:0] cfg_reg;
  reg [7:0] tofs_reg;
  reg [7:0] thr2_reg;
  reg [7:0] duty2_reg;
  reg [7:0] thr3_reg;
  reg [7:0] duty3_reg;
  reg [7:0] thr4_reg;
  reg [7:0] duty_next;
  reg duty_valid_next;
  reg [7:0] rd_data;
  reg mapped;
  wire [7:0] reg_idx;
  wire wr_en;
  wire [7:0] wr_data;
  wire unlocked;
  wire lut_wr;
  wire thi;
  wire dhi;
  wire f22k;
  wire [23:0] thr_bus;
  wire [2:0] above;
  wire [7:0] thr2_view;
  wire [7:0] duty2_view;
  wire [7:0] thr3_view;
  wire [7:0] duty3_view;
  wire [7:0] thr4_view;

  assign thi = cfg_reg[`FLUT_CFG_THI_BIT];
  assign dhi = cfg_reg[`FLUT_CFG_DHI_BIT];
  assign f22k = cfg_reg[`FLUT_CFG_F22K_BIT];
  assign unlocked = unlock_reg[`FLUT_UNLOCK_BIT];

  // ************************************************
  // Functions
  // ************************************************
  // Entry register of the table
  function is_entry;
    input [7:0] idx;
    begin
      is_entry = (idx == `FLUT_IDX_THR2) | (idx == `FLUT_IDX_DUTY2) |
                 (idx == `FLUT_IDX_THR3) | (idx == `FLUT_IDX_DUTY3) |
                 (idx == `FLUT_IDX_THR4);
    end
  endfunction

  // Threshold as seen by a read
  function [7:0] thr_view;
    input [7:0] v;
    input hi;
    begin
      thr_view = hi ? v : {1'b0, v[6:0]};
    end
  endfunction

  // Duty as seen by a read
  function [7:0] duty_view;
    input [7:0] v;
    input hi;
    begin
      duty_view = hi ? v : {2'b00, v[`FLUT_DUTY_LOW_MSB:0]};
    end
  endfunction

  // Duty applied to the fan
  function [7:0] duty_eff;
    input [7:0] v;
    input hi;
    input fast;
    begin
      duty_eff = (hi & fast) ? v : {2'b00, v[`FLUT_DUTY_LOW_MSB:0]};
    end
  endfunction

  // ************************************************
  // Bus front end
  // ************************************************
  flut_apb_slave u_apb
  (
    .sys_clk_i(sys_clk_i),
    .rst_i(rst_i),
    .ce_i(ce_i),
    .psel_i(psel_i),
    .penable_i(penable_i),
    .pwrite_i(pwrite_i),
    .paddr_i(paddr_i),
    .pwdata_i(pwdata_i),
    .prdata_o(prdata_o),
    .pready_o(pready_o),
    .pslverr_o(pslverr_o),
    .reg_idx_o(reg_idx),
    .wr_en_o(wr_en),
    .wr_data_o(wr_data),
    .rd_data_i(rd_data),
    .mapped_i(mapped)
  );

  assign lut_wr = wr_en & unlocked & is_entry(reg_idx); // RULE15

  // ************************************************
  // Control registers
  // ************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      unlock_reg <= `FLUT_RST_UNLOCK;
      cfg_reg <= `FLUT_RST_CFG;
      tofs_reg <= `FLUT_RST_TOFS;
    end
    else if (ce_i & wr_en)
    begin
      case (reg_idx)
        `FLUT_IDX_UNLOCK:
          unlock_reg <= wr_data;
        `FLUT_IDX_CFG:
          cfg_reg <= wr_data[2:0];
        `FLUT_IDX_TOFS:
          tofs_reg <= wr_data; // RULE9
        default:
          unlock_reg <= unlock_reg;
      endcase
    end
  end

  // ************************************************
  // Table entry registers
  // ************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      thr2_reg <= `FLUT_RST_THR;
      duty2_reg <= `FLUT_RST_DUTY;
      thr3_reg <= `FLUT_RST_THR; // RULE2
      duty3_reg <= `FLUT_RST_DUTY; // RULE10 RULE11
      thr4_reg <= `FLUT_RST_THR; // RULE14
    end
    else if (ce_i & lut_wr)
    begin
      case (reg_idx)
        `FLUT_IDX_THR2:
          thr2_reg <= wr_data;
        `FLUT_IDX_DUTY2:
          duty2_reg <= wr_data; // RULE1
        `FLUT_IDX_THR3:
          thr3_reg <= wr_data;
        `FLUT_IDX_DUTY3:
          duty3_reg <= wr_data; // RULE10
        `FLUT_IDX_THR4:
          thr4_reg <= wr_data;
        default:
          thr2_reg <= thr2_reg;
      endcase
    end
  end

  // ************************************************
  // Read views of the entry registers
  // ************************************************
  assign thr2_view = thr_view(thr2_reg, thi);
  assign duty2_view = duty_view(duty2_reg, dhi);
  assign thr3_view = thr_view(thr3_reg, thi); // RULE3 RULE4
  assign duty3_view = duty_view(duty3_reg, dhi); // RULE11 RULE12
  assign thr4_view = thr_view(thr4_reg, thi);

  // ************************************************
  // Read mux
  // ************************************************
  always @*
  begin
    rd_data = 8'h00;
    mapped = 1'b1;
    case (reg_idx)
      `FLUT_IDX_UNLOCK:
        rd_data = unlock_reg;
      `FLUT_IDX_CFG:
        rd_data = {5'h00, cfg_reg};
      `FLUT_IDX_TOFS:
        rd_data = tofs_reg;
      `FLUT_IDX_THR2:
        rd_data = thr2_view;
      `FLUT_IDX_DUTY2:
        rd_data = duty2_view;
      `FLUT_IDX_THR3:
        rd_data = thr3_view; // RULE3 RULE4
      `FLUT_IDX_DUTY3:
        rd_data = duty3_view; // RULE11 RULE12
      `FLUT_IDX_THR4:
        rd_data = thr4_view;
      default:
        mapped = 1'b0;
    endcase
  end

  // ************************************************
  // Threshold comparators, entries two to four
  // ************************************************
  assign thr_bus = {thr4_reg, thr3_reg, thr2_reg};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi = gi + 1)
    begin : g_cmp
      flut_thr_cmp u_cmp
      (
        .thr_i(thr_bus[gi * 8 +: 8]),
        .ofs_i(tofs_reg),
        .temp_i(remote_temp_i),
        .thi_i(thi),
        .above_o(above[gi])
      );
    end
  endgenerate

  // ************************************************
  // Duty selection
  // ************************************************
  always @*
  begin
    duty_next = 8'h00;
    duty_valid_next = 1'b0;
    if (above[2])
    begin
      // Entry four wins; its duty lives outside this slice
      duty_next = 8'h00; // RULE16
      duty_valid_next = 1'b0;
    end
    else if (above[1])
    begin
      duty_next = duty_eff(duty3_reg, dhi, f22k); // RULE7 RULE12 RULE13 RULE16
      duty_valid_next = 1'b1;
    end
    else if (above[0])
    begin
      duty_next = duty_eff(duty2_reg, dhi, f22k); // RULE1 RULE13
      duty_valid_next = 1'b1;
    end
  end

  // ************************************************
  // Output registers
  // ************************************************
  always @(posedge sys_clk_i or posedge rst_i)
  begin
    if (rst_i)
    begin
      duty_o <= 8'h00;
      duty_valid_o <= 1'b0;
      entry_above_o <= 3'h0;
    end
    else if (ce_i)
    begin
      duty_o <= duty_next;
      duty_valid_o <= duty_valid_next;
      entry_above_o <= above;
    end
  end

endmodule // flut_regs_top

// [test/flut_properties.sv]
// Port assertions for the fan table register slice
`timescale 1ns/100ps
module flut_checker
(
  // Clock, reset, enable
  input wire sys_clk_i,
  input wire rst_i,
  input wire ce_i,
  // APB
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  // Result path
  input wire [8:0] remote_temp_i,
  input wire [7:0] duty_o,
  input wire duty_valid_o,
  input wire [2:0] entry_above_o
);
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  // ************************
  // Assertions
  // ************************
  setup_answer_a: assert property (psel_i && !penable_i && ce_i |=> pready_o)
    else $error("no answer after setup");
  answer_cause_a: assert property (pready_o && $past(ce_i) |-> $past(psel_i && !penable_i))
    else $error("answer without setup");
  err_with_ready_a: assert property (pslverr_o |-> pready_o)
    else $error("error flag without ready");
  read_upper_a: assert property (pready_o |-> prdata_o[31:8] == 24'h000000)
    else $error("read data upper bits set");
  valid_map_a: assert property (duty_valid_o == (!entry_above_o[2] && |entry_above_o[1:0]))
    else $error("valid flag disagrees with entries");
  top_entry_a: assert property (entry_above_o[2] |-> duty_o == 8'h00 && !duty_valid_o)
    else $error("entry four passed with duty");
  zero_temp_a: assert property (remote_temp_i == 9'h000 && ce_i |=> entry_above_o == 3'h0)
    else $error("zero temperature passed a limit");
  ce_freeze_a: assert property (!ce_i |=> $stable(duty_o) && $stable(pready_o))
    else $error("outputs moved while disabled");
  cover property (psel_i && penable_i && pwrite_i && pready_o);
  cover property (pslverr_o);
  cover property (entry_above_o == 3'b011);
endmodule // flut_checker
bind flut_regs_top flut_checker chk (.sys_clk_i, .rst_i, .ce_i, .psel_i, .penable_i,
  .pwrite_i, .prdata_o, .pready_o, .pslverr_o, .remote_temp_i, .duty_o, .duty_valid_o,
  .entry_above_o);

// [test/flut_regs_top_bench.sv]
// Self-checking bench for the fan table register slice
`timescale 1ns/100ps
module flut_regs_top_bench;
  logic sys_clk, rst, ce, psel, penable, pwrite, pready, pslverr, dvalid, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [8:0] temp;
  logic [7:0] duty;
  logic [2:0] above;
  int err_count = 0;
  int n_compared = 0;
  // Cfg, address, write data, expected read
  logic [11:0] rows [6][4] = '{'{12'h0, 12'h150, 12'hFF, 12'h7F},
    '{12'h1, 12'h150, 12'hFF, 12'hFF}, '{12'h0, 12'h154, 12'hFF, 12'h3F},
    '{12'h2, 12'h154, 12'hFF, 12'hFF}, '{12'h0, 12'h14C, 12'h2A, 12'h2A},
    '{12'h0, 12'h158, 12'h80, 12'h00}};
  flut_regs_top dut (.sys_clk_i(sys_clk), .rst_i(rst), .ce_i(ce), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .remote_temp_i(temp),
    .duty_o(duty), .duty_valid_o(dvalid), .entry_above_o(above));
  // ************************
  // Tasks
  // ************************
  task chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      err_count++;
      $display("unexpected %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= {24'h000000, d};
    @(posedge sys_clk);
    penable <= 1'b1;
    do
      @(posedge sys_clk);
    while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task res(input logic [8:0] t, input logic [7:0] d);
    @(posedge sys_clk);
    temp <= t;
    repeat (3) @(posedge sys_clk);
    chk("duty", duty, d);
  endtask
  task wrap_up;
    $display("compared %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // ************************
  // Sequence
  // ************************
  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end
  initial
  begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    wrap_up;
  end
  initial
  begin
    rst = 1'b1;
    ce = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    temp = 9'h000;
    repeat (6) @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b1, 12'h128, 8'h20);
    foreach (rows[i])
    begin
      apb(1'b1, 12'h130, rows[i][0][7:0]);
      apb(1'b1, rows[i][1], rows[i][2][7:0]);
      apb(1'b0, rows[i][1], 8'h00);
      chk("read back", rd, {24'h0, rows[i][3][7:0]});
    end
    apb(1'b1, 12'h128, 8'h00);
    apb(1'b1, 12'h150, 8'h10);
    apb(1'b0, 12'h150, 8'h00);
    chk("locked write", rd, 32'h7F);
    apb(1'b0, 12'h000, 8'h00);
    chk("error flag", err, 32'h1);
    chk("error data", rd, 32'h0);
    @(posedge sys_clk);
    rst <= 1'b1;
    @(posedge sys_clk);
    rst <= 1'b0;
    apb(1'b1, 12'h130, 8'h03);
    apb(1'b0, 12'h150, 8'h00);
    chk("thr3 reset", rd, 32'h7F);
    apb(1'b0, 12'h154, 8'h00);
    chk("duty3 reset", rd, 32'h3F);
    apb(1'b0, 12'h158, 8'h00);
    chk("thr4 reset", rd, 32'h7F);
    apb(1'b1, 12'h128, 8'h20);
    apb(1'b1, 12'h130, 8'h00);
    apb(1'b1, 12'h148, 8'h1E);
    apb(1'b1, 12'h14C, 8'h0A);
    apb(1'b1, 12'h150, 8'h32);
    apb(1'b1, 12'h154, 8'hD5);
    res(9'd101, 8'h0A);
    res(9'd102, 8'h15);
    chk("valid", dvalid, 32'h1);
    apb(1'b1, 12'h130, 8'h01);
    res(9'd100, 8'h0A);
    res(9'd101, 8'h15);
    apb(1'b1, 12'h130, 8'h02);
    res(9'd102, 8'h15);
    apb(1'b1, 12'h130, 8'h06);
    res(9'd102, 8'hD5);
    apb(1'b1, 12'h130, 8'h00);
    apb(1'b1, 12'h138, 8'h02);
    res(9'd104, 8'h0A);
    res(9'd106, 8'h15);
    res(9'h1FF, 8'h00);
    chk("entries", above, 32'h7);
    chk("entry valid", dvalid, 32'h0);
    ce <= 1'b0;
    temp <= 9'd101;
    repeat (3) @(posedge sys_clk);
    chk("frozen duty", duty, 32'h0);
    ce <= 1'b1;
    repeat (2) @(posedge sys_clk);
    chk("duty resumed", duty, 32'h0A);
    wrap_up;
  end
endmodule // flut_regs_top_bench
